/* File: hdl/gauge_i2c_pkg.sv */
// constants, types and function list for the two-wire register slave
// Function
// - works at any bus rate to 400 kHz, no speed setting needed
// - every byte is followed by an acknowledge from the receiver
// - presence check: START, address and direction, then acknowledge sampled
// - seven-bit bus address, then direction bit: zero write, one read
// - in writes device drives data line only in acknowledge cycles
// - write pointer steps after each data byte's acknowledge clock
// - write bytes beyond address 4Fh are discarded
// - a register changes only when both its bytes are written
// - writes to read-only addresses leave contents unchanged
// - partial or unacknowledged bytes are never stored
// - device owns data line in reads except master acknowledge cycles
// - reads send MSB first and step pointer after each byte
// - master not-acknowledge ends the read; device releases the line
// - device presents a coherent byte pair within one read
// - reads past the top byte address return FFh
// - reserved addresses may return any value
// - only bus address 6Ch write / 6Dh read is answered
// - high byte first, held at the even address of each pair
package gauge_i2c_pkg;
	localparam logic [6:0] DEV_ADDR = 7'h36;
	localparam logic [7:0] WR_LAST = 8'h4F;
	localparam logic [7:0] RO_LAST = 8'h0B;
	localparam logic [7:0] FILL_BYTE = 8'hFF;
	localparam logic [7:0] MEM_RST = 8'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	localparam logic [8:0] PTR_STEP = 9'h001;
	localparam int MEM_DEPTH = 256;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR_BYTE,
		ST_WR_ACK,
		ST_RD_BYTE,
		ST_RD_ACK
	} link_st_e;
endpackage

/* File: hdl/level_sync.sv */
// two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module level_sync
	import gauge_i2c_pkg::*;
#(
	parameter int W = 1
)(
	input wire logic clk_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} state_s;

	state_s s_ff;
	state_s nxt_s;

	// no reset: also used to bring the reset itself into a domain
	always_comb
	begin
		nxt_s.meta = d_i;
		nxt_s.sync = s_ff.meta;
	end

	always_ff @(posedge clk_i)
	begin
		s_ff <= nxt_s;
	end

	assign q_o = s_ff.sync;
endmodule // level_sync

/* File: hdl/toggle_sync.sv */
// toggle-to-pulse crossing for single events
`timescale 1ns/1ps
module toggle_sync
	import gauge_i2c_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tgl_i,
	output logic pulse_o
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} state_s;

	state_s s_ff;
	state_s nxt_s;

	always_comb
	begin
		nxt_s.meta = tgl_i;
		nxt_s.sync = s_ff.meta;
		nxt_s.last = s_ff.sync;
		if (!rst_n_i)
		begin
			nxt_s = '0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		s_ff <= nxt_s;
	end

	assign pulse_o = s_ff.sync ^ s_ff.last;
endmodule // toggle_sync

/* File: hdl/gauge_i2c_slave.sv */
// two-wire slave giving a bus master access to byte-pair registers
`timescale 1ns/1ps
module gauge_i2c_slave
	import gauge_i2c_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic link_clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	output logic wr_valid_o,
	output logic [7:0] wr_addr_o,
	output logic [15:0] wr_data_o,
	input wire logic upd_valid_i,
	input wire logic [7:0] upd_addr_i,
	input wire logic [15:0] upd_data_i,
	output logic upd_ready_o
);
	typedef struct packed {
		link_st_e st;
		logic [3:0] bcnt;
		logic [7:0] sh;
		logic [8:0] ptr;
		logic rw;
		logic first;
		logic nack;
		logic hi_pend;
		logic [7:0] hi;
		logic [7:0] lo;
		logic lo_ok;
		logic oe_n;
		logic sda_lvl;
		logic scl_q;
		logic sda_q;
		logic cmt_tgl;
		logic [7:0] cmt_addr;
		logic [15:0] cmt_data;
		logic upd_ack_tgl;
		logic [MEM_DEPTH-1:0][7:0] mem;
	} link_s;

	typedef struct packed {
		logic wr_valid;
		logic [7:0] wr_addr;
		logic [15:0] wr_data;
		logic upd_tgl;
		logic upd_rdy;
		logic [7:0] upd_addr;
		logic [15:0] upd_data;
	} core_s;

	link_s l_ff;
	link_s nxt_l;
	core_s c_ff;
	core_s nxt_c;

	logic link_rst_n;
	logic scl_s;
	logic sda_s;
	logic cmt_p;
	logic upd_req_p;
	logic upd_ack_p;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic wr_ok;
	logic [7:0] rd_byte;

	// reset reaches the link domain through its own synchroniser
	level_sync #(
		.W(1)
	) u_rst_sync (
		.clk_i(link_clk_i),
		.d_i(rst_n_i),
		.q_o(link_rst_n)
	);

	// pins are oversampled on the link clock; no rate setting needed
	level_sync #(
		.W(2)
	) u_pin_sync (
		.clk_i(link_clk_i),
		.d_i({scl_i, sda_i}),
		.q_o({scl_s, sda_s})
	);

	toggle_sync u_cmt_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tgl_i(l_ff.cmt_tgl),
		.pulse_o(cmt_p)
	);

	toggle_sync u_upd_req_sync (
		.clk_i(link_clk_i),
		.rst_n_i(link_rst_n),
		.tgl_i(c_ff.upd_tgl),
		.pulse_o(upd_req_p)
	);

	toggle_sync u_upd_ack_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tgl_i(l_ff.upd_ack_tgl),
		.pulse_o(upd_ack_p)
	);

	assign scl_rise = scl_s & ~l_ff.scl_q;
	assign scl_fall = ~scl_s & l_ff.scl_q;
	assign start_ev = scl_s & l_ff.scl_q & l_ff.sda_q & ~sda_s;
	assign stop_ev = scl_s & l_ff.scl_q & ~l_ff.sda_q & sda_s;

	// writable window lies above the read-only block and up to 4Fh
	assign wr_ok = !l_ff.ptr[8] && l_ff.ptr[7:0] <= WR_LAST
		&& l_ff.ptr[7:0] > RO_LAST;

	// odd byte comes from the snapshot taken with its high byte
	always_comb
	begin
		if (l_ff.ptr[8])
		begin
			rd_byte = FILL_BYTE;
		end
		else if (l_ff.ptr[0] && l_ff.lo_ok)
		begin
			rd_byte = l_ff.lo;
		end
		else
		begin
			rd_byte = l_ff.mem[l_ff.ptr[7:0]];
		end
	end

	always_comb
	begin
		nxt_l = l_ff;
		nxt_l.scl_q = scl_s;
		nxt_l.sda_q = sda_s;
		nxt_l.sda_lvl = 1'b0;
		if (upd_req_p)
		begin
			nxt_l.mem[{c_ff.upd_addr[7:1], 1'b0}] = c_ff.upd_data[15:8];
			nxt_l.mem[{c_ff.upd_addr[7:1], 1'b1}] = c_ff.upd_data[7:0];
			nxt_l.upd_ack_tgl = ~l_ff.upd_ack_tgl;
		end
		if (start_ev)
		begin
			nxt_l.st = ST_ADDR;
			nxt_l.bcnt = '0;
			nxt_l.oe_n = 1'b1;
			nxt_l.hi_pend = 1'b0;
			nxt_l.lo_ok = 1'b0;
		end
		else if (stop_ev)
		begin
			nxt_l.st = ST_IDLE;
			nxt_l.oe_n = 1'b1;
			nxt_l.hi_pend = 1'b0;
		end
		else
		begin
			unique case (l_ff.st)
				ST_IDLE: nxt_l.oe_n = 1'b1;
				ST_ADDR:
				begin
					if (scl_rise)
					begin
						nxt_l.sh = {l_ff.sh[6:0], sda_s};
						nxt_l.bcnt = l_ff.bcnt + 4'h1;
					end
					else if (scl_fall && l_ff.bcnt == BYTE_BITS)
					begin
						// direction bit rides in the low bit of the byte
						if (l_ff.sh[7:1] == DEV_ADDR)
						begin
							nxt_l.oe_n = 1'b0;
							nxt_l.rw = l_ff.sh[0];
							nxt_l.st = ST_ADDR_ACK;
						end
						else
						begin
							nxt_l.st = ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						nxt_l.bcnt = '0;
						if (l_ff.rw)
						begin
							// keep the line from the ack straight into bit 7
							nxt_l.sh = {rd_byte[6:0], 1'b0};
							nxt_l.oe_n = rd_byte[7];
							nxt_l.lo = l_ff.mem[{l_ff.ptr[7:1], 1'b1}];
							nxt_l.lo_ok = ~l_ff.ptr[0] & ~l_ff.ptr[8];
							nxt_l.st = ST_RD_BYTE;
						end
						else
						begin
							nxt_l.oe_n = 1'b1;
							nxt_l.first = 1'b1;
							nxt_l.st = ST_WR_BYTE;
						end
					end
				end
				ST_WR_BYTE:
				begin
					if (scl_rise)
					begin
						nxt_l.sh = {l_ff.sh[6:0], sda_s};
						nxt_l.bcnt = l_ff.bcnt + 4'h1;
					end
					else if (scl_fall && l_ff.bcnt == BYTE_BITS)
					begin
						nxt_l.oe_n = 1'b0;
						nxt_l.st = ST_WR_ACK;
					end
				end
				ST_WR_ACK:
				begin
					if (scl_fall)
					begin
						// the byte is used only once its ack clock is over
						nxt_l.oe_n = 1'b1;
						nxt_l.bcnt = '0;
						nxt_l.st = ST_WR_BYTE;
						if (l_ff.first)
						begin
							nxt_l.ptr = {1'b0, l_ff.sh};
							nxt_l.first = 1'b0;
							nxt_l.hi_pend = 1'b0;
						end
						else
						begin
							if (!wr_ok)
							begin
								nxt_l.hi_pend = 1'b0;
							end
							else if (!l_ff.ptr[0])
							begin
								nxt_l.hi_pend = 1'b1;
								nxt_l.hi = l_ff.sh;
							end
							else if (l_ff.hi_pend)
							begin
								nxt_l.mem[{l_ff.ptr[7:1], 1'b0}] = l_ff.hi;
								nxt_l.mem[l_ff.ptr[7:0]] = l_ff.sh;
								nxt_l.cmt_addr = {l_ff.ptr[7:1], 1'b0};
								nxt_l.cmt_data = {l_ff.hi, l_ff.sh};
								nxt_l.cmt_tgl = ~l_ff.cmt_tgl;
								nxt_l.hi_pend = 1'b0;
							end
							if (!l_ff.ptr[8])
							begin
								nxt_l.ptr = l_ff.ptr + PTR_STEP;
							end
						end
					end
				end
				ST_RD_BYTE:
				begin
					if (scl_fall)
					begin
						if (l_ff.bcnt == LAST_TX_BIT)
						begin
							nxt_l.oe_n = 1'b1;
							nxt_l.bcnt = '0;
							nxt_l.st = ST_RD_ACK;
							if (!l_ff.ptr[8])
							begin
								nxt_l.ptr = l_ff.ptr + PTR_STEP;
							end
						end
						else
						begin
							nxt_l.oe_n = l_ff.sh[7];
							nxt_l.sh = {l_ff.sh[6:0], 1'b0};
							nxt_l.bcnt = l_ff.bcnt + 4'h1;
						end
					end
				end
				ST_RD_ACK:
				begin
					if (scl_rise)
					begin
						nxt_l.nack = sda_s;
					end
					else if (scl_fall)
					begin
						if (l_ff.nack)
						begin
							nxt_l.st = ST_IDLE;
						end
						else
						begin
							nxt_l.sh = {rd_byte[6:0], 1'b0};
							nxt_l.oe_n = rd_byte[7];
							nxt_l.lo = l_ff.mem[{l_ff.ptr[7:1], 1'b1}];
							nxt_l.lo_ok = ~l_ff.ptr[0] & ~l_ff.ptr[8];
							nxt_l.st = ST_RD_BYTE;
						end
					end
				end
			endcase
		end
		if (!link_rst_n)
		begin
			nxt_l = '0;
			nxt_l.oe_n = 1'b1;
			nxt_l.scl_q = 1'b1;
			nxt_l.sda_q = 1'b1;
			for (int i = 0; i < MEM_DEPTH; i++)
			begin
				nxt_l.mem[i] = MEM_RST;
			end
		end
	end

	always_ff @(posedge link_clk_i)
	begin
		l_ff <= nxt_l;
	end

	// commit words stay still long after the event pulse arrives
	always_comb
	begin
		nxt_c = c_ff;
		nxt_c.wr_valid = cmt_p;
		if (cmt_p)
		begin
			nxt_c.wr_addr = l_ff.cmt_addr;
			nxt_c.wr_data = l_ff.cmt_data;
		end
		if (upd_ack_p)
		begin
			nxt_c.upd_rdy = 1'b1;
		end
		else if (upd_valid_i && c_ff.upd_rdy)
		begin
			// held until the link side has stored the pair
			nxt_c.upd_addr = upd_addr_i;
			nxt_c.upd_data = upd_data_i;
			nxt_c.upd_tgl = ~c_ff.upd_tgl;
			nxt_c.upd_rdy = 1'b0;
		end
		if (!rst_n_i)
		begin
			nxt_c = '0;
			nxt_c.upd_rdy = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		c_ff <= nxt_c;
	end

	assign sda_o = l_ff.sda_lvl;
	assign sda_oe_n_o = l_ff.oe_n;
	assign wr_valid_o = c_ff.wr_valid;
	assign wr_addr_o = c_ff.wr_addr;
	assign wr_data_o = c_ff.wr_data;
	assign upd_ready_o = c_ff.upd_rdy;
endmodule // gauge_i2c_slave

/* File: sim/gauge_i2c_slave_props.sv */
// port assertions for the two-wire register slave
`timescale 1ns/1ps
module gauge_i2c_slave_props
	import gauge_i2c_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic link_clk_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic wr_valid_o,
	input wire logic [7:0] wr_addr_o,
	input wire logic upd_valid_i,
	input wire logic upd_ready_o
);
	a_drive_low_only: assert property (@(posedge link_clk_i)
		disable iff (!rst_n_i) !sda_oe_n_o |-> !sda_o)
		else $error("sda driven high");
	a_oe_quiet_high: assert property (@(posedge link_clk_i)
		disable iff (!rst_n_i) scl_i [*6] |-> $stable(sda_oe_n_o))
		else $error("sda moved while scl high");
	a_commit_single: assert property (@(posedge clk_i)
		disable iff (!rst_n_i) wr_valid_o |=> !wr_valid_o)
		else $error("commit pulse too long");
	a_pair_even: assert property (@(posedge clk_i)
		disable iff (!rst_n_i) wr_valid_o |-> !wr_addr_o[0])
		else $error("commit at odd address");
	a_commit_range: assert property (@(posedge clk_i)
		disable iff (!rst_n_i)
		wr_valid_o |-> wr_addr_o > RO_LAST && wr_addr_o <= WR_LAST)
		else $error("commit outside writable range");
	a_addr_held: assert property (@(posedge clk_i)
		disable iff (!rst_n_i) !wr_valid_o |-> $stable(wr_addr_o))
		else $error("commit address moved");
	a_upd_taken: assert property (@(posedge clk_i)
		disable iff (!rst_n_i) upd_valid_i && upd_ready_o |=> !upd_ready_o)
		else $error("update not taken");
	a_upd_returns: assert property (@(posedge clk_i)
		disable iff (!rst_n_i) $fell(upd_ready_o) |-> ##[1:40] upd_ready_o)
		else $error("update never stored");
endmodule // gauge_i2c_slave_props

bind gauge_i2c_slave gauge_i2c_slave_props props (.clk_i, .rst_n_i,
	.link_clk_i, .scl_i, .sda_o, .sda_oe_n_o, .wr_valid_o, .wr_addr_o,
	.upd_valid_i, .upd_ready_o);

/* File: sim/i2c_host_model.sv */
// behavioural two-wire bus master; scl stands high between frames
`timescale 1ns/1ps
module i2c_host_model #(
	parameter int HALF = 200
)(
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// also serves as repeated start: sda released before scl rises
	task automatic start();
		#HALF sda_low_o = 1'b0;
		#HALF scl_o = 1'b1;
		#HALF sda_low_o = 1'b1;
		#HALF scl_o = 1'b0;
	endtask
	task automatic stop();
		#HALF sda_low_o = 1'b1;
		#HALF scl_o = 1'b1;
		#HALF sda_low_o = 1'b0;
	endtask
	// data moves mid-low, clear of the device's late ack turn
	task automatic xfer(input logic b, output logic r);
		#HALF sda_low_o = !b;
		#HALF scl_o = 1'b1;
		#HALF r = sda_i;
		scl_o = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] tx, input logic ab,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
			xfer(tx[i], rx[i]);
		xfer(ab, ack);
	endtask
endmodule // i2c_host_model

/* File: sim/gauge_i2c_slave_tb.sv */
// self-checking bench for the two-wire register slave
`timescale 1ns/1ps
module gauge_i2c_slave_tb
	import gauge_i2c_pkg::*;
;
	logic clk_i, rst_n_i, link_clk_i, scl, sda_low, sda, sda_o, sda_oe_n_o;
	logic wr_valid_o, upd_valid_i, upd_ready_o;
	logic [7:0] wr_addr_o, upd_addr_i;
	logic [15:0] wr_data_o, upd_data_i;
	logic [23:0] commits[$];
	logic [31:0] got;
	int err_total = 0;
	int total_checks = 0;

	assign sda = !sda_low && (sda_oe_n_o || sda_o);
	gauge_i2c_slave dut (.clk_i, .rst_n_i, .link_clk_i, .scl_i(scl),
		.sda_i(sda), .sda_o, .sda_oe_n_o, .wr_valid_o, .wr_addr_o,
		.wr_data_o, .upd_valid_i, .upd_addr_i, .upd_data_i, .upd_ready_o);
	i2c_host_model host (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial
	begin
		link_clk_i = 1'b0;
		#3;
		forever #7.5 link_clk_i = ~link_clk_i;
	end
	always @(posedge clk_i)
		if (wr_valid_o === 1'b1)
			commits.push_back({wr_addr_o, wr_data_o});

	task automatic final_report();
		if (err_total == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic pop_chk(input logic [23:0] e);
		logic [23:0] g;
		g = 'x;
		if (commits.size() > 0)
			g = commits.pop_front();
		chk(g, e);
	endtask
	task automatic addr_ptr(input logic [7:0] ptr);
		logic [7:0] rx;
		logic ack;
		host.start();
		host.byte_io(8'h6C, 1'b1, rx, ack);
		chk(ack, 1'b0);
		host.byte_io(ptr, 1'b1, rx, ack);
		chk(ack, 1'b0);
	endtask
	task automatic bus_write(input logic [7:0] p, input logic [31:0] d,
		input int n);
		logic [7:0] rx;
		logic ack;
		addr_ptr(p);
		for (int i = 0; i < n; i++)
		begin
			host.byte_io(d[31-8*i -: 8], 1'b1, rx, ack);
			chk(ack, 1'b0);
		end
		host.stop();
		repeat (40) @(posedge clk_i);
	endtask
	task automatic bus_read(input logic [7:0] p, input int n);
		logic [7:0] rx;
		logic ack;
		got = '0;
		addr_ptr(p);
		host.start();
		host.byte_io(8'h6D, 1'b1, rx, ack);
		chk(ack, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			host.byte_io(8'hFF, i == n - 1, rx, ack);
			got[31-8*i -: 8] = rx;
		end
		#200;
		chk(sda, 1'b1);
		host.stop();
	endtask
	task automatic upd(input logic [7:0] a, input logic [15:0] d);
		int n;
		@(posedge clk_i);
		upd_valid_i <= 1'b1;
		upd_addr_i <= a;
		upd_data_i <= d;
		@(posedge clk_i);
		upd_valid_i <= 1'b0;
		@(posedge clk_i);
		for (n = 0; n < 100 && upd_ready_o !== 1'b1; n++)
			@(posedge clk_i);
		if (n == 100)
		begin
			chk(32'h0, 32'h1);
			final_report();
		end
	endtask

	task automatic s_presence();
		logic [7:0] rx;
		logic ack;
		host.start();
		host.byte_io(8'h6C, 1'b1, rx, ack);
		chk(ack, 1'b0);
		host.stop();
		host.start();
		host.byte_io(8'h6E, 1'b1, rx, ack);
		chk(ack, 1'b1);
		host.stop();
	endtask
	task automatic s_write_read();
		bus_write(8'h0C, 32'h11223344, 4);
		pop_chk(24'h0C1122);
		pop_chk(24'h0E3344);
		bus_read(8'h0C, 4);
		chk(got, 32'h11223344);
	endtask
	task automatic s_top_and_ro();
		bus_write(8'h4E, 32'hA1B2C3D4, 4);
		pop_chk(24'h4EA1B2);
		upd(8'h02, 16'hABCD);
		bus_write(8'h02, 32'h55660000, 2);
		chk(commits.size(), 0);
		bus_read(8'h02, 2);
		chk(got, 32'hABCD0000);
		bus_read(8'h0C, 1);
		chk(got, 32'h11000000);
		bus_read(8'h03, 1);
		chk(got, 32'hCD000000);
		bus_read(8'hFE, 4);
		chk(got[15:0], 16'hFFFF);
	endtask
	task automatic s_partial();
		logic [7:0] rx;
		logic ack;
		bus_write(8'h10, 32'h77000000, 1);
		bus_write(8'h11, 32'h88990000, 2);
		// lone high byte cut by a repeated start, then a lone low byte
		addr_ptr(8'h12);
		host.byte_io(8'hAA, 1'b1, rx, ack);
		chk(ack, 1'b0);
		bus_write(8'h13, 32'hBB000000, 1);
		chk(commits.size(), 0);
		bus_read(8'h10, 4);
		chk(got, 32'h0);
	endtask

	initial
	begin
		rst_n_i = 1'b0;
		upd_valid_i = 1'b0;
		upd_addr_i = 8'h00;
		upd_data_i = 16'h0000;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		s_presence();
		s_write_read();
		s_top_and_ro();
		s_partial();
		final_report();
	end
endmodule // gauge_i2c_slave_tb
